// ### pkg/asx_pkg.sv
// Constants for the subtract, nibble-exchange, XOR and direction-load datapath.
// Assumes the decoder supplies a one-hot-free opcode code from this package.
package asx_pkg;
  // ==========================================================
  // Opcodes
  typedef enum logic [2:0] {
    ASX_OP_NONE = 3'h0,
    ASX_OP_SUB_ACC_FROM_FILE = 3'h1,
    ASX_OP_SUB_WITH_BORROW = 3'h2,
    ASX_OP_NIBBLE_EXCHANGE = 3'h3,
    ASX_OP_XOR_LITERAL_INTO_ACC = 3'h4,
    ASX_OP_XOR_ACC_WITH_FILE = 3'h5,
    ASX_OP_PIN_DIRECTION_LOAD = 3'h6
  } asx_op_type;

  // ==========================================================
  // Operand limits and reset values
  localparam logic [6:0] ASX_FILE_ADDR_MAX = 7'h7F;
  localparam logic [6:0] ASX_DIR_SEL_A = 7'h05;
  localparam logic [6:0] ASX_DIR_SEL_B = 7'h06;
  localparam logic [6:0] ASX_DIR_SEL_C = 7'h07;
  localparam logic ASX_DEST_ACC = 1'h0;
  localparam logic ASX_DEST_FILE = 1'h1;
  localparam logic [7:0] ASX_ACC_RESET = 8'h00;
  localparam logic [7:0] ASX_DIR_RESET = 8'hFF;
  localparam int ASX_NIB_HI = 7;
  localparam int ASX_NIB_LO = 3;
endpackage

// ### rtl/asx_alu.sv
// Execution datapath for subtract, nibble exchange, XOR and direction load.
// Assumes the decoder holds op/operands for one cycle with op_valid; file read
// data arrives combinationally for file_addr in the same cycle.
// How it works
// - File minus accumulator, two's complement, address 0 to 127.
// - Carry set when acc not above file, nibble borrow when acc low nibble not above file low nibble; zero updated.
// - Borrow subtract: file minus acc minus inverted carry; all three flags.
// - Nibble exchange swaps file nibbles into destination; flags untouched.
// - XOR literal into accumulator; only zero flag changes.
// - XOR accumulator with file into destination; only zero flag changes.
// - Direction load accepts 5, 6, 7 only; copies acc to port A, B, C.
// - Destination bit 0 writes accumulator, 1 writes addressed file register.
module asx_alu (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic op_valid,
  input wire asx_pkg::asx_op_type op,
  input wire logic [6:0] file_addr,
  input wire logic [7:0] literal,
  input wire logic dest_sel,
  input wire logic [7:0] file_rdata,
  output logic [7:0] acc,
  output logic carry_flag,
  output logic nibble_borrow_flag,
  output logic zero_flag,
  output logic file_we,
  output logic [6:0] file_waddr,
  output logic [7:0] file_wdata,
  output logic [7:0] port_a_direction,
  output logic [7:0] port_b_direction,
  output logic [7:0] port_c_direction
);
  // ==========================================================
  // Helpers
  // Carry in high means no borrow; carry out high means a was not below b
  function automatic logic [8:0] asx_sub(input logic [7:0] a, input logic [7:0] b,
                                         input logic cin);
    asx_sub = {1'h0, a} + {1'h0, ~b} + {8'h00, cin};
  endfunction

  function automatic logic [4:0] asx_sub4(input logic [3:0] a, input logic [3:0] b,
                                          input logic cin);
    asx_sub4 = {1'h0, a} + {1'h0, ~b} + {4'h0, cin};
  endfunction

  // ==========================================================
  // Next-state logic
  logic [7:0] next_acc;
  logic next_carry_flag;
  logic next_nibble_borrow_flag;
  logic next_zero_flag;
  logic next_file_we;
  logic [6:0] next_file_waddr;
  logic [7:0] next_file_wdata;
  logic [7:0] next_port_a_direction;
  logic [7:0] next_port_b_direction;
  logic [7:0] next_port_c_direction;

  always_comb begin
    logic [8:0] diff;
    logic [4:0] ndiff;
    logic [7:0] res;
    logic wr_res;
    diff = 9'h000;
    ndiff = 5'h00;
    res = 8'h00;
    wr_res = 1'h0;
    next_acc = acc;
    next_carry_flag = carry_flag;
    next_nibble_borrow_flag = nibble_borrow_flag;
    next_zero_flag = zero_flag;
    next_file_we = 1'h0;
    next_file_waddr = file_waddr;
    next_file_wdata = file_wdata;
    next_port_a_direction = port_a_direction;
    next_port_b_direction = port_b_direction;
    next_port_c_direction = port_c_direction;
    if (op_valid) begin
      unique case (op)
        asx_pkg::ASX_OP_SUB_ACC_FROM_FILE, asx_pkg::ASX_OP_SUB_WITH_BORROW: begin
          if (op == asx_pkg::ASX_OP_SUB_ACC_FROM_FILE) begin
            diff = asx_sub(file_rdata, acc, 1'h1);
            ndiff = asx_sub4(file_rdata[3:0], acc[3:0], 1'h1);
          end else begin
            diff = asx_sub(file_rdata, acc, carry_flag);
            ndiff = asx_sub4(file_rdata[3:0], acc[3:0], carry_flag);
          end
          res = diff[7:0];
          wr_res = 1'h1;
          next_carry_flag = diff[8];
          next_nibble_borrow_flag = ndiff[4];
          next_zero_flag = (res == 8'h00);
        end
        asx_pkg::ASX_OP_NIBBLE_EXCHANGE: begin
          res = {file_rdata[asx_pkg::ASX_NIB_LO:0],
                 file_rdata[asx_pkg::ASX_NIB_HI:asx_pkg::ASX_NIB_LO + 1]};
          wr_res = 1'h1;
        end
        asx_pkg::ASX_OP_XOR_LITERAL_INTO_ACC: begin
          next_acc = acc ^ literal;
          next_zero_flag = ((acc ^ literal) == 8'h00);
        end
        asx_pkg::ASX_OP_XOR_ACC_WITH_FILE: begin
          res = acc ^ file_rdata;
          wr_res = 1'h1;
          next_zero_flag = (res == 8'h00);
        end
        asx_pkg::ASX_OP_PIN_DIRECTION_LOAD: begin
          if (file_addr == asx_pkg::ASX_DIR_SEL_A) begin
            next_port_a_direction = acc;
          end else if (file_addr == asx_pkg::ASX_DIR_SEL_B) begin
            next_port_b_direction = acc;
          end else if (file_addr == asx_pkg::ASX_DIR_SEL_C) begin
            next_port_c_direction = acc;
          end
        end
        default: begin
        end
      endcase
      if (wr_res) begin
        if (dest_sel == asx_pkg::ASX_DEST_ACC) begin
          next_acc = res;
        end else begin
          next_file_we = 1'h1;
          next_file_waddr = file_addr;
          next_file_wdata = res;
        end
      end
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      acc <= asx_pkg::ASX_ACC_RESET;
      carry_flag <= 1'h0;
      nibble_borrow_flag <= 1'h0;
      zero_flag <= 1'h0;
      file_we <= 1'h0;
      file_waddr <= 7'h00;
      file_wdata <= 8'h00;
      port_a_direction <= asx_pkg::ASX_DIR_RESET;
      port_b_direction <= asx_pkg::ASX_DIR_RESET;
      port_c_direction <= asx_pkg::ASX_DIR_RESET;
    end else begin
      acc <= next_acc;
      carry_flag <= next_carry_flag;
      nibble_borrow_flag <= next_nibble_borrow_flag;
      zero_flag <= next_zero_flag;
      file_we <= next_file_we;
      file_waddr <= next_file_waddr;
      file_wdata <= next_file_wdata;
      port_a_direction <= next_port_a_direction;
      port_b_direction <= next_port_b_direction;
      port_c_direction <= next_port_c_direction;
    end
  end

  // ==========================================================
  // Checks
  sequence s_sub;
    op_valid && op == asx_pkg::ASX_OP_SUB_ACC_FROM_FILE;
  endsequence

  property p_sub_result;
    @(posedge clk) disable iff (sys_rst)
    s_sub and (dest_sel == 1'h0) |=> acc == $past(file_rdata) - $past(acc);
  endproperty
  a_sub_result: assert property (p_sub_result) else $error("subtract result wrong");

  property p_sub_carry;
    @(posedge clk) disable iff (sys_rst)
    s_sub |=> carry_flag == ($past(acc) <= $past(file_rdata))
      && nibble_borrow_flag == ($past(acc[3:0]) <= $past(file_rdata[3:0]));
  endproperty
  a_sub_carry: assert property (p_sub_carry) else $error("subtract carry wrong");

  property p_subb;
    @(posedge clk) disable iff (sys_rst)
    op_valid && op == asx_pkg::ASX_OP_SUB_WITH_BORROW && dest_sel == 1'h0
      |=> acc == 8'($past(file_rdata) - $past(acc) - 8'({7'h00, ~$past(carry_flag)}));
  endproperty
  a_subb: assert property (p_subb) else $error("borrow subtract wrong");

  property p_swap;
    @(posedge clk) disable iff (sys_rst)
    op_valid && op == asx_pkg::ASX_OP_NIBBLE_EXCHANGE && dest_sel == 1'h1
      |=> file_we && file_wdata == {$past(file_rdata[3:0]), $past(file_rdata[7:4])}
      && $stable(zero_flag) && $stable(carry_flag) && $stable(nibble_borrow_flag);
  endproperty
  a_swap: assert property (p_swap) else $error("nibble exchange wrong");

  property p_xorl;
    @(posedge clk) disable iff (sys_rst)
    op_valid && op == asx_pkg::ASX_OP_XOR_LITERAL_INTO_ACC
      |=> acc == ($past(acc) ^ $past(literal)) && $stable(carry_flag) && !file_we;
  endproperty
  a_xorl: assert property (p_xorl) else $error("xor literal wrong");

  property p_xorf;
    @(posedge clk) disable iff (sys_rst)
    op_valid && op == asx_pkg::ASX_OP_XOR_ACC_WITH_FILE
      |=> $stable(carry_flag) && $stable(nibble_borrow_flag);
  endproperty
  a_xorf: assert property (p_xorf) else $error("xor file touched carry");

  property p_dir;
    @(posedge clk) disable iff (sys_rst)
    op_valid && op == asx_pkg::ASX_OP_PIN_DIRECTION_LOAD && file_addr == asx_pkg::ASX_DIR_SEL_B
      |=> port_b_direction == $past(acc) && $stable(port_a_direction) && $stable(zero_flag);
  endproperty
  a_dir: assert property (p_dir) else $error("direction load wrong");

  property p_dest;
    @(posedge clk) disable iff (sys_rst)
    op_valid && op == asx_pkg::ASX_OP_XOR_ACC_WITH_FILE && dest_sel == 1'h1
      |=> file_we && file_waddr == $past(file_addr) && $stable(acc);
  endproperty
  a_dest: assert property (p_dest) else $error("destination select wrong");

  property p_zero;
    @(posedge clk) disable iff (sys_rst)
    op_valid && op == asx_pkg::ASX_OP_XOR_ACC_WITH_FILE
      |=> zero_flag == ($past(acc) == $past(file_rdata));
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");
endmodule

// ### dv/asx_file_model.sv
// File register space facing the datapath, with a combinational read port.
// Assumes writes arrive as one-cycle file_we pulses from the datapath.
module asx_file_model (
  input wire logic clk,
  input wire logic [6:0] file_addr,
  input wire logic file_we,
  input wire logic [6:0] file_waddr,
  input wire logic [7:0] file_wdata,
  output logic [7:0] file_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [128];
  initial for (int i = 0; i < 128; i++) mem[i] = 8'(i * 37);
  // Pending write is forwarded to a read of the same place
  assign file_rdata = (file_we && file_waddr == file_addr) ? file_wdata : mem[file_addr];
  always @(posedge clk) if (file_we) mem[file_waddr] <= file_wdata;
endmodule

// ### dv/alu_sub_swap_xor_ops_test.sv
// Self-checking test of the subtract, nibble-exchange, XOR and direction-load datapath.
// Assumes asx_file_model stands in for the file register space.
module alu_sub_swap_xor_ops_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic op_valid = 1'b0;
  asx_pkg::asx_op_type op = asx_pkg::ASX_OP_NONE;
  logic [6:0] file_addr = 7'h00;
  logic [7:0] literal = 8'h00;
  logic dest_sel = 1'b0;
  logic [7:0] file_rdata, acc, file_wdata, dir_a, dir_b, dir_c;
  logic carry_flag, nibble_borrow_flag, zero_flag, file_we;
  logic [6:0] file_waddr;
  int err_count = 0;
  int checks = 0;
  logic [50:0] notes [$];
  logic vld_d = 1'b0;
  logic [7:0] m_acc, m_wd, m_pa, m_pb, m_pc;
  logic [7:0] ref_mem [128];
  logic m_c, m_dc, m_z;
  logic [6:0] m_wa;
  logic [50:0] seen;
  assign seen = {acc, carry_flag, nibble_borrow_flag, zero_flag, file_we, file_wdata,
    file_waddr, dir_a, dir_b, dir_c};
  asx_alu DUT (.clk(clk), .sys_rst(sys_rst), .op_valid(op_valid), .op(op),
    .file_addr(file_addr), .literal(literal), .dest_sel(dest_sel), .file_rdata(file_rdata),
    .acc(acc), .carry_flag(carry_flag), .nibble_borrow_flag(nibble_borrow_flag),
    .zero_flag(zero_flag), .file_we(file_we), .file_waddr(file_waddr),
    .file_wdata(file_wdata), .port_a_direction(dir_a), .port_b_direction(dir_b),
    .port_c_direction(dir_c));
  asx_file_model u_file (.clk(clk), .file_addr(file_addr), .file_we(file_we),
    .file_waddr(file_waddr), .file_wdata(file_wdata), .file_rdata(file_rdata));
  initial forever #2.5 clk = ~clk;
  // ==========================================================
  // Checking and closing
  task automatic chk(input logic [50:0] got, input logic [50:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge clk) vld_d <= op_valid && !sys_rst;
  always @(negedge clk) if (vld_d)
    chk(seen, notes.pop_front());
  initial begin
    #20000;
    err_count++;
    close_out();
  end
  // ==========================================================
  // Stimulus with reference model
  task automatic do_reset();
    @(posedge clk);
    op_valid <= 1'b0;
    sys_rst <= 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    {m_acc, m_c, m_dc, m_z, m_wd, m_wa} = '0;
    {m_pa, m_pb, m_pc} = 24'hFFFFFF;
    @(negedge clk);
    chk(seen, {8'h00, 4'h0, 8'h00, 7'h00, 24'hFFFFFF});
  endtask
  task automatic issue(input logic [2:0] o, input logic [6:0] a, input logic [7:0] k,
    input logic d);
    logic [7:0] f, r;
    logic [8:0] t;
    logic [4:0] n;
    logic b, we;
    @(posedge clk);
    op_valid <= 1'b1;
    op <= asx_pkg::asx_op_type'(o);
    file_addr <= a;
    literal <= k;
    dest_sel <= d;
    f = ref_mem[a];
    r = f;
    we = 1'b0;
    b = (o == 3'h2) && !m_c;
    t = {1'b0, f} - {1'b0, m_acc} - {8'h00, b};
    n = {1'b0, f[3:0]} - {1'b0, m_acc[3:0]} - {4'h0, b};
    if (o == 3'h1 || o == 3'h2) begin
      r = t[7:0];
      {m_c, m_dc, m_z} = {~t[8], ~n[4], r == 8'h00};
    end
    if (o == 3'h3) r = {f[3:0], f[7:4]};
    if (o == 3'h5) r = m_acc ^ f;
    if (o == 3'h5) m_z = (r == 8'h00);
    if (o == 3'h4) m_acc = m_acc ^ k;
    if (o == 3'h4) m_z = (m_acc == 8'h00);
    if (o == 3'h6 && a == 7'h05) m_pa = m_acc;
    if (o == 3'h6 && a == 7'h06) m_pb = m_acc;
    if (o == 3'h6 && a == 7'h07) m_pc = m_acc;
    if ((o inside {3'h1, 3'h2, 3'h3, 3'h5}) && d) begin
      {we, m_wa, m_wd} = {1'b1, a, r};
      ref_mem[a] = r;
    end else if (o inside {3'h1, 3'h2, 3'h3, 3'h5}) begin
      m_acc = r;
    end
    notes.push_back({m_acc, m_c, m_dc, m_z, we, m_wd, m_wa, m_pa, m_pb, m_pc});
  endtask
  initial begin
    logic [2:0] o;
    logic [6:0] a;
    for (int i = 0; i < 128; i++) ref_mem[i] = 8'(i * 37);
    void'($urandom(31));
    for (int i = 0; i < 600; i++) begin
      if (i % 300 == 0) do_reset();
      o = 3'(i % 8);
      a = (i % 3 == 0) ? 7'h7F : 7'($urandom_range(2));
      if (o == 3'h6) a = 7'(4 + $urandom_range(4));
      issue(o, a, 8'($urandom), 1'($urandom));
      if ($urandom_range(3) == 0) @(posedge clk) op_valid <= 1'b0;
    end
    @(posedge clk);
    op_valid <= 1'b0;
    repeat (2) @(posedge clk);
    close_out();
  end
endmodule
